// file: include/bdls_pkg.sv
// Purpose: Shared constants for the bias drive and disconnect detection register bank
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register indices are multiplied by four to form byte addresses

package bdls_pkg;

	localparam int BDLS_MAX_CH = 8;

	// Register indices; byte address is four times the index
	localparam logic [7:0] BDLS_IDX_BIAS_POS = 8'h0d;
	localparam logic [7:0] BDLS_IDX_BIAS_NEG = 8'h0e;
	localparam logic [7:0] BDLS_IDX_DET_POS = 8'h0f;
	localparam logic [7:0] BDLS_IDX_DET_NEG = 8'h10;
	localparam logic [7:0] BDLS_IDX_POLARITY = 8'h11;
	localparam logic [7:0] BDLS_IDX_STAT_POS = 8'h12;
	localparam logic [7:0] BDLS_IDX_STAT_NEG = 8'h13;
	localparam logic [7:0] BDLS_IDX_IRQ_STAT = 8'h14;
	localparam logic [7:0] BDLS_IDX_IRQ_MASK = 8'h15;

	localparam logic [7:0] BDLS_CFG_RESET = 8'h00;
	localparam logic [15:0] BDLS_IRQ_RESET = 16'h0000;
	localparam logic [31:0] BDLS_RDATA_RESET = 32'h0000_0000;

	// Interrupt layout: positive inputs in bits 7:0, negative in 15:8
	localparam int BDLS_IRQ_POS_LSB = 0;
	localparam int BDLS_IRQ_NEG_LSB = 8;

	function automatic logic [7:0] bdls_addr_of(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction

	// Bits present for a part with ch channels (4, 6 or 8)
	function automatic logic [7:0] bdls_chan_mask(input int ch);
		if (ch <= 4) begin
			return 8'h0f;
		end
		if (ch <= 6) begin
			return 8'h3f;
		end
		return 8'hff;
	endfunction

endpackage

// file: verilog/bdls_sync.sv
// Purpose: Two-flop synchroniser for the analog comparator outputs
// Assumes: Inputs change asynchronously to pclk
// Notes: Only the second stage may be read by other logic

`timescale 1ns/1ps

module bdls_sync #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_q <= '0;
			stage2_q <= '0;
		end else begin
			stage1_q <= async_in;
			stage2_q <= stage1_q;
		end
	end

	assign sync_out = stage2_q;

endmodule

// file: verilog/bdls_regs.sv
// Purpose: APB register bank for bias drive input selection and electrode disconnect detection
// Assumes: pclk 125 MHz, presetn asynchronous active low, comparator inputs asynchronous
// Notes: Every transfer takes one setup and one access cycle; no wait states
//
// What this block does
// R1: Register 0Dh bit n-1 routes channel n positive input into bias drive.
// R2: Register 0Eh bit n-1 routes channel n negative input into bias drive.
// R3: Register 0Fh bit n-1 enables disconnect detection on channel n positive input.
// R4: Register 10h bit n-1 enables disconnect detection on channel n negative input.
// R5: Register 11h holds one pull direction bit per channel.
// R6: Software ignores a disconnect status bit whose detection enable is clear.
// R7: Bits 5:4 absent on four-channel parts; bits 7:6 absent below eight channels.
// R8: All five configuration registers reset to zero.
// R9: Polarity 0 pulls positive input high, negative low; 1 swaps them.
// R10: Disconnect status bit reads 0 when attached, 1 when electrode is off.
//
// The implementer's own choice: register access over APB.

`timescale 1ns/1ps

module bdls_regs import bdls_pkg::*; #(
	parameter int CHANNELS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] disconnect_raw_pos,
	input wire logic [7:0] disconnect_raw_neg,
	output logic [7:0] bias_drive_pos_route,
	output logic [7:0] bias_drive_neg_route,
	output logic [7:0] detect_pos_enable,
	output logic [7:0] detect_neg_enable,
	output logic [7:0] pull_polarity,
	output logic [7:0] pos_pull_high,
	output logic [7:0] neg_pull_high,
	output logic irq
);

	localparam logic [7:0] CH_MASK = bdls_chan_mask(CHANNELS);

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
		return addr == bdls_addr_of(idx);
	endfunction

	// Configuration registers
	logic [7:0] bias_drive_positive_select_q, bias_drive_positive_select_d;
	logic [7:0] bias_drive_negative_select_q, bias_drive_negative_select_d;
	logic [7:0] disconnect_detect_positive_enable_q, disconnect_detect_positive_enable_d;
	logic [7:0] disconnect_detect_negative_enable_q, disconnect_detect_negative_enable_d;
	logic [7:0] disconnect_pull_polarity_q, disconnect_pull_polarity_d;
	logic [7:0] pos_pull_high_q, pos_pull_high_d;
	logic [7:0] neg_pull_high_q, neg_pull_high_d;

	// Status and interrupt state
	logic [7:0] sync_pos, sync_neg;
	logic [7:0] disconnect_status_positive_q, disconnect_status_positive_d;
	logic [7:0] disconnect_status_negative_q, disconnect_status_negative_d;
	logic [15:0] irq_stat_q, irq_stat_d;
	logic [15:0] irq_mask_q, irq_mask_d;
	logic [15:0] irq_event;
	logic irq_q, irq_d;

	// Bus answer
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic setup_phase, access_done, wr_en, rd_done, addr_ok;

	bdls_sync #(
		.WIDTH(8)
	) u_sync_pos (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(disconnect_raw_pos),
		.sync_out(sync_pos)
	);

	bdls_sync #(
		.WIDTH(8)
	) u_sync_neg (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(disconnect_raw_neg),
		.sync_out(sync_neg)
	);

	// Bus phases; pready rises in the access phase only
	always_comb begin
		setup_phase = psel && !penable;
		access_done = psel && penable && pready_q;
		addr_ok = hit(paddr, BDLS_IDX_BIAS_POS) || hit(paddr, BDLS_IDX_BIAS_NEG) ||
			hit(paddr, BDLS_IDX_DET_POS) || hit(paddr, BDLS_IDX_DET_NEG) ||
			hit(paddr, BDLS_IDX_POLARITY) || hit(paddr, BDLS_IDX_STAT_POS) ||
			hit(paddr, BDLS_IDX_STAT_NEG) || hit(paddr, BDLS_IDX_IRQ_STAT) ||
			hit(paddr, BDLS_IDX_IRQ_MASK);
		wr_en = access_done && pwrite && !pslverr_q && pstrb[0];
		rd_done = access_done && !pwrite && !pslverr_q;
	end

	// Configuration writes; absent channel bits never store a one
	always_comb begin
		bias_drive_positive_select_d = bias_drive_positive_select_q;
		bias_drive_negative_select_d = bias_drive_negative_select_q;
		disconnect_detect_positive_enable_d = disconnect_detect_positive_enable_q;
		disconnect_detect_negative_enable_d = disconnect_detect_negative_enable_q;
		disconnect_pull_polarity_d = disconnect_pull_polarity_q;
		irq_mask_d = irq_mask_q;
		if (wr_en && hit(paddr, BDLS_IDX_BIAS_POS)) begin
			bias_drive_positive_select_d = pwdata[7:0] & CH_MASK; // R1 R7
		end
		if (wr_en && hit(paddr, BDLS_IDX_BIAS_NEG)) begin
			bias_drive_negative_select_d = pwdata[7:0] & CH_MASK; // R2 R7
		end
		if (wr_en && hit(paddr, BDLS_IDX_DET_POS)) begin
			disconnect_detect_positive_enable_d = pwdata[7:0] & CH_MASK; // R3 R7
		end
		if (wr_en && hit(paddr, BDLS_IDX_DET_NEG)) begin
			disconnect_detect_negative_enable_d = pwdata[7:0] & CH_MASK; // R4 R7
		end
		if (wr_en && hit(paddr, BDLS_IDX_POLARITY)) begin
			disconnect_pull_polarity_d = pwdata[7:0] & CH_MASK; // R5 R7
		end
		if (access_done && pwrite && !pslverr_q && hit(paddr, BDLS_IDX_IRQ_MASK)) begin
			if (pstrb[0]) begin
				irq_mask_d[7:0] = pwdata[7:0] & CH_MASK;
			end
			if (pstrb[1]) begin
				irq_mask_d[15:8] = pwdata[15:8] & CH_MASK;
			end
		end
		pos_pull_high_d = ~disconnect_pull_polarity_d & CH_MASK; // R9
		neg_pull_high_d = disconnect_pull_polarity_d; // R9
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_drive_positive_select_q <= BDLS_CFG_RESET; // R8
			bias_drive_negative_select_q <= BDLS_CFG_RESET; // R8
			disconnect_detect_positive_enable_q <= BDLS_CFG_RESET; // R8
			disconnect_detect_negative_enable_q <= BDLS_CFG_RESET; // R8
			disconnect_pull_polarity_q <= BDLS_CFG_RESET; // R8
			pos_pull_high_q <= CH_MASK;
			neg_pull_high_q <= BDLS_CFG_RESET;
			irq_mask_q <= BDLS_IRQ_RESET;
		end else begin
			bias_drive_positive_select_q <= bias_drive_positive_select_d;
			bias_drive_negative_select_q <= bias_drive_negative_select_d;
			disconnect_detect_positive_enable_q <= disconnect_detect_positive_enable_d;
			disconnect_detect_negative_enable_q <= disconnect_detect_negative_enable_d;
			disconnect_pull_polarity_q <= disconnect_pull_polarity_d;
			pos_pull_high_q <= pos_pull_high_d;
			neg_pull_high_q <= neg_pull_high_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	// Status follows the comparators even when detection is off, so that
	// enabling a channel does not fire on stale history; software masks it.
	always_comb begin
		disconnect_status_positive_d = sync_pos & CH_MASK; // R10
		disconnect_status_negative_d = sync_neg & CH_MASK; // R10
		irq_event[BDLS_IRQ_POS_LSB +: 8] = disconnect_status_positive_d & ~disconnect_status_positive_q &
			disconnect_detect_positive_enable_q; // R6
		irq_event[BDLS_IRQ_NEG_LSB +: 8] = disconnect_status_negative_d & ~disconnect_status_negative_q &
			disconnect_detect_negative_enable_q; // R6
		irq_stat_d = irq_stat_q;
		// Only bits that the read reported are cleared; one set at the setup edge waits for the next read
		if (rd_done && hit(paddr, BDLS_IDX_IRQ_STAT)) begin
			irq_stat_d = irq_stat_q & ~prdata_q[15:0];
		end
		// A new event in the clearing cycle survives
		irq_stat_d = irq_stat_d | irq_event;
		irq_d = |(irq_stat_d & irq_mask_d);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disconnect_status_positive_q <= BDLS_CFG_RESET;
			disconnect_status_negative_q <= BDLS_CFG_RESET;
			irq_stat_q <= BDLS_IRQ_RESET;
			irq_q <= 1'b0;
		end else begin
			disconnect_status_positive_q <= disconnect_status_positive_d;
			disconnect_status_negative_q <= disconnect_status_negative_d;
			irq_stat_q <= irq_stat_d;
			irq_q <= irq_d;
		end
	end

	// Read data is captured in the setup phase so it stands out of a flop
	always_comb begin
		prdata_d = prdata_q;
		pready_d = setup_phase;
		pslverr_d = 1'b0;
		if (setup_phase) begin
			prdata_d = BDLS_RDATA_RESET;
			pslverr_d = !addr_ok;
			if (!pwrite) begin
				unique case (1'b1)
					hit(paddr, BDLS_IDX_BIAS_POS): prdata_d[7:0] = bias_drive_positive_select_q;
					hit(paddr, BDLS_IDX_BIAS_NEG): prdata_d[7:0] = bias_drive_negative_select_q;
					hit(paddr, BDLS_IDX_DET_POS): prdata_d[7:0] = disconnect_detect_positive_enable_q;
					hit(paddr, BDLS_IDX_DET_NEG): prdata_d[7:0] = disconnect_detect_negative_enable_q;
					hit(paddr, BDLS_IDX_POLARITY): prdata_d[7:0] = disconnect_pull_polarity_q;
					hit(paddr, BDLS_IDX_STAT_POS): prdata_d[7:0] = disconnect_status_positive_q;
					hit(paddr, BDLS_IDX_STAT_NEG): prdata_d[7:0] = disconnect_status_negative_q;
					hit(paddr, BDLS_IDX_IRQ_STAT): prdata_d[15:0] = irq_stat_q;
					hit(paddr, BDLS_IDX_IRQ_MASK): prdata_d[15:0] = irq_mask_q;
					default: prdata_d = BDLS_RDATA_RESET;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= BDLS_RDATA_RESET;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign bias_drive_pos_route = bias_drive_positive_select_q;
	assign bias_drive_neg_route = bias_drive_negative_select_q;
	assign detect_pos_enable = disconnect_detect_positive_enable_q;
	assign detect_neg_enable = disconnect_detect_negative_enable_q;
	assign pull_polarity = disconnect_pull_polarity_q;
	assign pos_pull_high = pos_pull_high_q;
	assign neg_pull_high = neg_pull_high_q;
	assign irq = irq_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_bias_pos_write: assert property ( // R1
		wr_en && hit(paddr, BDLS_IDX_BIAS_POS) |=> bias_drive_pos_route == ($past(pwdata[7:0]) & CH_MASK))
		else $error("positive bias select did not take the written value");

	chk_bias_neg_write: assert property ( // R2
		wr_en && hit(paddr, BDLS_IDX_BIAS_NEG) |=> bias_drive_neg_route == ($past(pwdata[7:0]) & CH_MASK))
		else $error("negative bias select did not take the written value");

	chk_det_pos_write: assert property ( // R3
		wr_en && hit(paddr, BDLS_IDX_DET_POS) |=> detect_pos_enable == ($past(pwdata[7:0]) & CH_MASK))
		else $error("positive detect enable did not take the written value");

	chk_det_neg_write: assert property ( // R4
		wr_en && hit(paddr, BDLS_IDX_DET_NEG) |=> detect_neg_enable == ($past(pwdata[7:0]) & CH_MASK))
		else $error("negative detect enable did not take the written value");

	chk_polarity_hold: assert property ( // R5
		!(access_done && pwrite && hit(paddr, BDLS_IDX_POLARITY)) |=> $stable(pull_polarity))
		else $error("polarity changed without a write");

	chk_absent_bits_zero: assert property ( // R7
		((bias_drive_pos_route | bias_drive_neg_route | detect_pos_enable | detect_neg_enable |
		pull_polarity) & ~CH_MASK) == 8'h00)
		else $error("absent channel bit is set");

	chk_reset_values: assert property ( // R8
		$rose(presetn) |-> bias_drive_pos_route == 8'h00 && detect_neg_enable == 8'h00 &&
		pull_polarity == 8'h00)
		else $error("configuration not zero after reset");

	chk_pull_swap: assert property ( // R9
		neg_pull_high == pull_polarity && pos_pull_high == (~pull_polarity & CH_MASK))
		else $error("pull directions do not match polarity");

	chk_status_latency: assert property ( // R10
		$rose(disconnect_raw_pos[0]) ##1 disconnect_raw_pos[0] [*2] |=> disconnect_status_positive_q[0])
		else $error("status did not follow comparator within three cycles");

	chk_event_sticky: assert property ( // R6
		irq_event != 16'h0000 |=> (irq_stat_q & $past(irq_event)) == $past(irq_event))
		else $error("enabled disconnect event lost");

	chk_unread_kept: assert property (
		rd_done && hit(paddr, BDLS_IDX_IRQ_STAT) |=>
		(($past(irq_stat_q) & ~$past(prdata_q[15:0])) & ~irq_stat_q) == 16'h0000)
		else $error("unreported interrupt status bit was cleared");

	chk_read_answer: assert property (
		setup_phase ##1 (psel && penable) |-> pready)
		else $error("access phase without ready");

endmodule

// file: tb/bdls_regs_test.sv
// Purpose: Self-checking bench for the bias drive and disconnect detection register bank
// Assumes: APB slave answers without wait states; comparator inputs driven directly
// Notes: Reads push their expectation; a monitor pops and compares on each completed read

`timescale 1ns/1ps

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end

module bdls_regs_test;
	import bdls_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	logic [7:0] raw_pos = 8'h00, raw_neg = 8'h00;
	logic [7:0] bpos, bneg, dpos, dneg, pol, pph, nph, bpos4, pph4;
	logic [32:0] exp_q[$];
	logic [32:0] exp_v;
	logic [7:0] idx_tab [5] = '{BDLS_IDX_BIAS_POS, BDLS_IDX_BIAS_NEG, BDLS_IDX_DET_POS, BDLS_IDX_DET_NEG,
		BDLS_IDX_POLARITY};
	logic [7:0] v;
	int fail_count = 0;
	int samples_checked = 0;
	int seed = 58;

	always #4 pclk = ~pclk;

	bdls_regs #(.CHANNELS(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .disconnect_raw_pos(raw_pos), .disconnect_raw_neg(raw_neg),
		.bias_drive_pos_route(bpos), .bias_drive_neg_route(bneg), .detect_pos_enable(dpos),
		.detect_neg_enable(dneg), .pull_polarity(pol), .pos_pull_high(pph), .neg_pull_high(nph), .irq(irq));

	// Four-channel variant shares the bus; only its outputs are watched, never its read data
	bdls_regs #(.CHANNELS(4)) dut4_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
		.disconnect_raw_pos(raw_pos), .disconnect_raw_neg(raw_neg), .bias_drive_pos_route(bpos4),
		.bias_drive_neg_route(), .detect_pos_enable(), .detect_neg_enable(), .pull_polarity(),
		.pos_pull_high(pph4), .neg_pull_high(), .irq());

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Request stands until a rising edge samples ready high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, idx, 32'h0000_0000, 4'h0);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, 4'hf);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("wrong value read queue expected %h seen %h", 1, 0);
			end else begin
				exp_v = exp_q.pop_front();
				`CHK("read response", exp_v, {pslverr, prdata})
			end
		end
	end

	initial begin
		#160000;
		fail_count++;
		print_verdict();
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK("outputs after reset", 40'h0, {bpos, bneg, dpos, dneg, pol})
		`CHK("pull after reset", 16'hff00, {pph, nph})
		`CHK("narrow pull after reset", 8'h0f, pph4)
		for (int i = 0; i < 5; i++) begin
			rd(idx_tab[i], 33'h0);
		end
		$display("test reset done");

		for (int i = 0; i < 5; i++) begin
			v = 8'($random(seed));
			wr(idx_tab[i], {24'hffffff, v});
			rd(idx_tab[i], {25'h0, v});
			@(negedge pclk);
			`CHK("config port", v, ({bpos, bneg, dpos, dneg, pol} >> (8 * (4 - i))) & 40'hff)
		end
		$display("test readback done");

		// Disabled strobe must leave the register alone
		apb(1'b1, BDLS_IDX_POLARITY, 32'h0000_00a5, 4'he);
		@(negedge pclk);
		`CHK("masked strobe", v, pol)
		wr(BDLS_IDX_POLARITY, 32'h0000_00c3);
		@(negedge pclk);
		`CHK("pull pair", {8'h3c, 8'hc3}, {pph, nph})
		`CHK("polarity", 8'hc3, pol)
		wr(BDLS_IDX_BIAS_POS, 32'h0000_00ff);
		@(negedge pclk);
		`CHK("narrow route", 8'h0f, bpos4)
		rd(8'h16, {1'b1, 32'h0});
		$display("test polarity and variant done");

		wr(BDLS_IDX_DET_POS, 32'h0000_0001);
		wr(BDLS_IDX_DET_NEG, 32'h0000_0001);
		apb(1'b1, BDLS_IDX_IRQ_MASK, 32'h0000_0101, 4'h3);
		rd(BDLS_IDX_IRQ_STAT, 33'h0);
		// Bit 1 is not enabled, so its status is shown but raises no event
		@(posedge pclk);
		raw_pos <= 8'h03;
		repeat (5) @(negedge pclk);
		`CHK("irq raised", 1'b1, irq)
		rd(BDLS_IDX_STAT_POS, {25'h0, 8'h03});
		rd(BDLS_IDX_IRQ_STAT, {17'h0, 16'h0001});
		repeat (2) @(negedge pclk);
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b1, BDLS_IDX_IRQ_MASK, 32'h0000_0000, 4'h3);
		@(posedge pclk);
		raw_neg <= 8'h01;
		repeat (5) @(negedge pclk);
		`CHK("irq masked", 1'b0, irq)
		rd(BDLS_IDX_STAT_NEG, {25'h0, 8'h01});
		rd(BDLS_IDX_IRQ_STAT, {17'h0, 16'h0100});
		$display("test disconnect events done");
		repeat (3) @(posedge pclk);
		`CHK("pending reads", 0, exp_q.size())
		print_verdict();
	end
endmodule
